// File: hw/event_trigger_sequencer.sv
// Trigger sequencer for one power module on a shared backplane trigger line
// How it works
// - With link drive selected, a constant-voltage to constant-current change drives the line.
// - An armed module waits the programmed delay after a trigger before applying its level.
// - A zero delay applies the triggered level right after the trigger.
// - The module can drive the line and also be triggered by its own pulse.
// - Immediate and triggered setpoints are held apart; a trigger switches to the triggered one.
// - The backplane trigger line can be chosen as the trigger source.
// - Triggers are ignored until an arm command has been given.
// - The line is driven only while drive is enabled; drive source is selectable.
// - A service request can be raised once the triggered level is applied.
// - A fault indicator output can be raised on a regulation status change.
// - Waiting-for-trigger shows as bit 5 of the operation status.
// - A host bus trigger command can be chosen as the trigger source.
`timescale 1ns/1ns
`default_nettype none
`include "trig_seq_cfg.svh"
module event_trigger_sequencer #(
  parameter int          DATA_W               = 16,
  parameter logic [31:0] DEFAULT_DELAY_CYCLES = `TRIG_DELAY_CYC
) (
  // Clock, reset, clock enable
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic                ce,
  // AXI4-Lite write address and data
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [`ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  // AXI4-Lite write response
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output var  logic [1:0]          s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  input  wire logic [`ADDR_W-1:0]  s_axi_araddr,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output var  logic [31:0]         s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  // Backplane trigger line, open drain, active low
  input  wire logic                backplane_trigger_line_n_in,
  output var  logic                backplane_trigger_line_n_out,
  output var  logic                backplane_trigger_line_n_oe,
  // Regulation state, high in constant current
  input  wire logic                constant_current_state,
  // Module outputs
  output var  logic [DATA_W-1:0]   setpoint,
  output var  logic                fault_indicator_output,
  output var  logic                irq
);
  import trig_seq_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  seq_state_t            state_r;
  trig_src_t             trig_src_r;
  drv_src_t              drv_src_r;
  logic                  drv_en_r;
  logic                  fault_en_r;
  logic [DATA_W-1:0]     imm_level_r;
  logic [DATA_W-1:0]     trig_level_r;
  logic [31:0]           delay_r;
  logic [31:0]           delay_lat_r;
  logic                  applied_r;
  logic [`INT_W-1:0]     int_stat_r;
  logic [`INT_W-1:0]     int_en_r;
  logic [`PULSE_W-1:0]   pulse_cnt_r;
  logic                  aw_full_r;
  logic                  w_full_r;
  logic [`ADDR_W-1:0]    aw_addr_r;
  logic [31:0]           w_data_r;
  logic [31:0]           w_mask_r;
  logic [31:0]           strb_mask;
  logic [31:0]           wd;
  logic                  wr_fire;
  logic                  cc_s;
  logic                  line_s;
  logic                  cc_prev_r;
  logic                  line_prev_r;
  logic                  cc_rise;
  logic                  cc_change;
  logic                  line_fall;
  logic                  arm_cmd;
  logic                  bus_trig_cmd;
  logic                  trig_event;
  logic                  tmr_start;
  logic                  tmr_busy;
  logic                  tmr_done;
  logic                  drv_start;
  logic [`INT_W-1:0]     int_set;
  logic [`INT_W-1:0]     int_clr;
  logic [`INT_W-1:0]     int_nxt;
  logic [31:0]           rd_data_c;
  logic                  rd_ok_c;
  logic [31:0]           dly_cnt_h;

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  pin_sync #(.W(2), .RESET_VAL(2'h1)) u_sync (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .ce        (ce),
    .pin_in    ({constant_current_state, backplane_trigger_line_n_in}),
    .level_out ({cc_s, line_s})
  );

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cc_prev_r   <= 1'b0;
      line_prev_r <= 1'b1;
    end else if (ce) begin
      cc_prev_r   <= cc_s;
      line_prev_r <= line_s;
    end
  end

  assign cc_rise   = cc_s & ~cc_prev_r;
  assign cc_change = cc_s ^ cc_prev_r;
  assign line_fall = line_prev_r & ~line_s;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_strb
    assign strb_mask[8*i +: 8] = {8{s_axi_wstrb[i]}};
  end

  assign wr_fire = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign wd      = w_data_r & w_mask_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      aw_full_r     <= 1'b0;
      aw_addr_r     <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r     <= s_axi_awaddr;
        aw_full_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_full_r     <= 1'b0;
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_wready <= 1'b1;
      w_full_r     <= 1'b0;
      w_data_r     <= '0;
      w_mask_r     <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r     <= s_axi_wdata;
        w_mask_r     <= strb_mask;
        w_full_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_full_r     <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr_r)
          `ADDR_CTRL, `ADDR_CMD, `ADDR_IMM_LEVEL, `ADDR_TRIG_LEVEL, `ADDR_DELAY,
          `ADDR_INT_CLEAR, `ADDR_INT_ENABLE: s_axi_bresp <= `RESP_OKAY;
          default:                           s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign arm_cmd      = wr_fire && aw_addr_r == `ADDR_CMD && wd[`CMD_ARM_BIT];
  assign bus_trig_cmd = wr_fire && aw_addr_r == `ADDR_CMD && wd[`CMD_TRIG_BIT];
  assign int_clr      = (wr_fire && aw_addr_r == `ADDR_INT_CLEAR) ? wd[`INT_W-1:0] : '0;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      trig_src_r   <= SRC_LINE;
      drv_src_r    <= DRV_BUS;
      drv_en_r     <= 1'b0;
      fault_en_r   <= 1'b0;
      imm_level_r  <= '0;
      trig_level_r <= '0;
      delay_r      <= DEFAULT_DELAY_CYCLES;
      int_en_r     <= '0;
    end else if (ce && wr_fire) begin
      case (aw_addr_r)
        `ADDR_CTRL: begin
          if (w_mask_r[0]) begin
            trig_src_r <= trig_src_t'(w_data_r[`CTRL_SRC_BIT]);
            drv_en_r   <= w_data_r[`CTRL_DRV_EN_BIT];
            drv_src_r  <= drv_src_t'(w_data_r[`CTRL_DRV_SRC_BIT]);
            fault_en_r <= w_data_r[`CTRL_FAULT_BIT];
          end
        end
        `ADDR_IMM_LEVEL:  imm_level_r  <= (imm_level_r & ~w_mask_r[DATA_W-1:0]) | wd[DATA_W-1:0];
        `ADDR_TRIG_LEVEL: trig_level_r <= (trig_level_r & ~w_mask_r[DATA_W-1:0]) | wd[DATA_W-1:0];
        `ADDR_DELAY:      delay_r      <= (delay_r & ~w_mask_r) | wd;
        `ADDR_INT_ENABLE: int_en_r     <= (int_en_r & ~w_mask_r[`INT_W-1:0]) | wd[`INT_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Trigger sequence
  // ----------------------------------------------------------------
  assign trig_event = (trig_src_r == SRC_BUS) ? bus_trig_cmd : line_fall;
  assign tmr_start  = (state_r == ST_ARMED) && trig_event;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      case (state_r)
        ST_IDLE:  if (arm_cmd) state_r <= ST_ARMED;
        ST_ARMED: if (trig_event) state_r <= ST_DELAY;
        ST_DELAY: if (tmr_done) state_r <= ST_IDLE;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  delay_timer #(.CNT_W(32)) u_timer (
    .ref_clk (ref_clk),
    .reset   (reset),
    .ce      (ce),
    .start   (tmr_start),
    .load    (delay_r),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // Setpoint follows the immediate level until the triggered level is applied
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      applied_r <= 1'b0;
      setpoint  <= '0;
    end else if (ce) begin
      if (state_r == ST_DELAY && tmr_done) begin
        applied_r <= 1'b1;
        setpoint  <= trig_level_r;
      end else if (wr_fire && aw_addr_r == `ADDR_IMM_LEVEL) begin
        applied_r <= 1'b0;
      end else if (!applied_r) begin
        setpoint  <= imm_level_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Backplane line drive
  // ----------------------------------------------------------------
  assign drv_start = drv_en_r && ((drv_src_r == DRV_LINK) ? cc_rise : bus_trig_cmd);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pulse_cnt_r                  <= '0;
      backplane_trigger_line_n_oe  <= 1'b0;
      backplane_trigger_line_n_out <= 1'b0;
    end else if (ce) begin
      backplane_trigger_line_n_out <= 1'b0;
      if (!drv_en_r) begin
        pulse_cnt_r <= '0;
      end else if (drv_start) begin
        pulse_cnt_r <= `PULSE_W'(`TRIG_PULSE_CYC);
      end else if (pulse_cnt_r != '0) begin
        pulse_cnt_r <= pulse_cnt_r - 1'b1;
      end
      backplane_trigger_line_n_oe <= drv_en_r && (drv_start || pulse_cnt_r > `PULSE_W'(1));
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and fault indicator
  // ----------------------------------------------------------------
  always_comb begin
    int_set                 = '0;
    int_set[`INT_TRIG_BIT]  = tmr_start;
    int_set[`INT_LEVEL_BIT] = (state_r == ST_DELAY) && tmr_done;
    int_set[`INT_CC_BIT]    = cc_rise;
    int_nxt                 = (int_stat_r & ~int_clr) | int_set;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      int_stat_r             <= '0;
      irq                    <= 1'b0;
      fault_indicator_output <= 1'b0;
    end else if (ce) begin
      int_stat_r <= int_nxt;
      irq        <= |(int_stat_r & int_en_r);
      if (!fault_en_r) begin
        fault_indicator_output <= 1'b0;
      end else begin
        fault_indicator_output <= (fault_indicator_output & ~int_clr[`INT_CC_BIT]) | cc_change;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_data_c = '0;
    rd_ok_c   = 1'b1;
    case (s_axi_araddr)
      `ADDR_CTRL: begin
        rd_data_c[`CTRL_SRC_BIT]     = trig_src_r;
        rd_data_c[`CTRL_DRV_EN_BIT]  = drv_en_r;
        rd_data_c[`CTRL_DRV_SRC_BIT] = drv_src_r;
        rd_data_c[`CTRL_FAULT_BIT]   = fault_en_r;
      end
      `ADDR_CMD, `ADDR_INT_CLEAR: rd_data_c = '0;
      `ADDR_IMM_LEVEL:  rd_data_c[DATA_W-1:0] = imm_level_r;
      `ADDR_TRIG_LEVEL: rd_data_c[DATA_W-1:0] = trig_level_r;
      `ADDR_DELAY:      rd_data_c = delay_r;
      `ADDR_STATUS: begin
        rd_data_c[`ST_CC_BIT]      = cc_s;
        rd_data_c[`ST_DELAY_BIT]   = tmr_busy;
        rd_data_c[`ST_APPLIED_BIT] = applied_r;
        rd_data_c[`ST_WAIT_BIT]    = (state_r == ST_ARMED);
      end
      `ADDR_INT_STATUS: rd_data_c[`INT_W-1:0] = int_stat_r;
      `ADDR_INT_ENABLE: rd_data_c[`INT_W-1:0] = int_en_r;
      default:          rd_ok_c = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data_c;
        s_axi_rresp   <= rd_ok_c ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      delay_lat_r <= '0;
      dly_cnt_h   <= '0;
    end else if (ce) begin
      if (tmr_start) delay_lat_r <= delay_r;
      dly_cnt_h <= (state_r == ST_DELAY) ? dly_cnt_h + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset || !ce);

  AST_LINK_DRIVE: assert property (drv_en_r && drv_src_r == DRV_LINK && cc_rise |=> backplane_trigger_line_n_oe)
    else $error("link drive missed a crossing");
  AST_DELAY_LEN: assert property (state_r == ST_DELAY && tmr_done |-> dly_cnt_h == delay_lat_r)
    else $error("trigger delay length wrong");
  AST_ZERO_DELAY: assert property (tmr_start && delay_r == '0 |=> ##1 applied_r && setpoint == trig_level_r)
    else $error("zero delay not applied at once");
  AST_SELF_TRIG: assert property (state_r == ST_ARMED && trig_src_r == SRC_LINE && line_fall |=> state_r == ST_DELAY)
    else $error("line trigger not taken");
  AST_HOLD_IMM: assert property (state_r != ST_DELAY && !applied_r |=> !applied_r || $past(state_r) == ST_DELAY)
    else $error("triggered level without trigger");
  AST_BUS_TRIG: assert property (state_r == ST_ARMED && trig_src_r == SRC_BUS && bus_trig_cmd |=> state_r == ST_DELAY)
    else $error("bus trigger not taken");
  AST_UNARMED: assert property (state_r == ST_IDLE && !arm_cmd |=> state_r == ST_IDLE)
    else $error("trigger taken while not armed");
  AST_NO_DRIVE: assert property (!drv_en_r |=> !backplane_trigger_line_n_oe)
    else $error("line driven while drive disabled");
  AST_PULSE_LEN: assert property ($rose(backplane_trigger_line_n_oe) |-> backplane_trigger_line_n_oe [*8])
    else $error("drive pulse too short");
  AST_ONE_EDGE: assert property (cc_s && cc_prev_r |-> !drv_start || drv_src_r == DRV_BUS)
    else $error("drive repeated while in constant current");
  AST_SRQ: assert property (state_r == ST_DELAY && tmr_done && int_en_r[`INT_LEVEL_BIT] |=> ##1 irq)
    else $error("service request missing");
  AST_FAULT: assert property (fault_en_r && cc_change |=> fault_indicator_output)
    else $error("fault indicator missed a change");

  COV_DELAYED: cover property (state_r == ST_DELAY && tmr_done && delay_lat_r != '0);
  COV_LINK_SELF: cover property (drv_src_r == DRV_LINK && drv_start ##[1:20] line_fall);
  COV_BUS_TRIG: cover property (trig_src_r == SRC_BUS && tmr_start);
endmodule : event_trigger_sequencer
`default_nettype wire

// File: hw/trig_seq_cfg.svh
// Offsets, field positions, reset values and timing counts of the trigger sequencer
`ifndef TRIG_SEQ_CFG_SVH
`define TRIG_SEQ_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ          25
`define TRIG_DELAY_US    15000
`define TRIG_DELAY_CYC   (`TRIG_DELAY_US * `CLK_MHZ)
`define TRIG_PULSE_NS    320
`define TRIG_PULSE_CYC   ((`TRIG_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define PULSE_W          4

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_W           6
`define ADDR_CTRL        6'h00
`define ADDR_CMD         6'h04
`define ADDR_IMM_LEVEL   6'h08
`define ADDR_TRIG_LEVEL  6'h0c
`define ADDR_DELAY       6'h10
`define ADDR_STATUS      6'h14
`define ADDR_INT_STATUS  6'h18
`define ADDR_INT_CLEAR   6'h1c
`define ADDR_INT_ENABLE  6'h20

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define CTRL_SRC_BIT     0
`define CTRL_DRV_EN_BIT  1
`define CTRL_DRV_SRC_BIT 2
`define CTRL_FAULT_BIT   3
`define CMD_ARM_BIT      0
`define CMD_TRIG_BIT     1
`define ST_CC_BIT        0
`define ST_DELAY_BIT     1
`define ST_APPLIED_BIT   2
`define ST_WAIT_BIT      5
`define INT_TRIG_BIT     0
`define INT_LEVEL_BIT    1
`define INT_CC_BIT       2
`define INT_W            3
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// File: hw/trig_seq_pkg.sv
// Types shared by the trigger sequencer files
`default_nettype none
package trig_seq_pkg;
  // Gray along IDLE -> ARMED -> DELAY; DELAY -> IDLE changes both bits
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ARMED = 2'h1,
    ST_DELAY = 2'h3
  } seq_state_t;

  typedef enum logic {
    SRC_LINE = 1'h0,
    SRC_BUS  = 1'h1
  } trig_src_t;

  typedef enum logic {
    DRV_BUS  = 1'h0,
    DRV_LINK = 1'h1
  } drv_src_t;
endpackage : trig_seq_pkg
`default_nettype wire

// File: hw/pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int         W         = 2,
  parameter logic [1:0] RESET_VAL = 2'h0
) (
  // Clock and control
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         ce,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] level_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_r      <= RESET_VAL[W-1:0];
      s2_r      <= RESET_VAL[W-1:0];
      s3_r      <= RESET_VAL[W-1:0];
      level_out <= RESET_VAL[W-1:0];
    end else if (ce) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A change counts once the second and third stages agree
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : pin_sync
`default_nettype wire

// File: hw/delay_timer.sv
// Down-counter that times the programmed trigger delay
`timescale 1ns/1ns
`default_nettype none
module delay_timer #(
  parameter int CNT_W = 32
) (
  // Clock and control
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             ce,
  // Start with a load value, done pulses when it has elapsed
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  output var  logic             busy,
  output var  logic             done
);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= load;
        busy  <= (load != '0);
        done  <= (load == '0);
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : delay_timer
`default_nettype wire

// File: tb/peer_model.sv
// Peer module sharing the open-drain backplane trigger line
`timescale 1ns/1ns
`default_nettype none
module peer_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Peer pulse request and the block's drive
  input  wire logic fire,
  input  wire logic dut_out_n,
  input  wire logic dut_oe,
  // Wire level
  output var  logic line_n
);
  logic [3:0] cnt_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) cnt_r <= 4'h0;
    else if (fire) cnt_r <= 4'h8;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  // Pull-up holds the line high unless a party pulls it low
  always_comb line_n = !((cnt_r != 4'h0) || (dut_oe && !dut_out_n));
endmodule : peer_model
`default_nettype wire

// File: tb/event_trigger_sequencer_bench.sv
// Self-checking bench for the trigger sequencer
`timescale 1ns/1ns
`default_nettype none
module event_trigger_sequencer_bench;
  logic ref_clk = 0, reset = 1, ce = 1, fire = 0, constant_current_state = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, seed = 67;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic backplane_trigger_line_n_in, backplane_trigger_line_n_out, backplane_trigger_line_n_oe;
  logic [15:0] setpoint, im, tl;
  logic fault_indicator_output;
  logic [33:0] q[$];
  int miscompares = 0, checked = 0, cyc = 0, n;
  event_trigger_sequencer #(.DEFAULT_DELAY_CYCLES(32'h14)) dut (
    .ref_clk, .reset, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .backplane_trigger_line_n_in, .backplane_trigger_line_n_out,
    .backplane_trigger_line_n_oe, .constant_current_state, .setpoint, .fault_indicator_output, .irq);
  peer_model peer (.ref_clk, .reset, .fire, .dut_out_n(backplane_trigger_line_n_out),
    .dut_oe(backplane_trigger_line_n_oe), .line_n(backplane_trigger_line_n_in));
  always #20 ref_clk = ~ref_clk;
  // ----
  // Helpers
  // ----
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task chk(input logic [33:0] s, input logic [33:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ad && dd)) begin
      @(posedge ref_clk);
      if (s_axi_awready === 1) begin ad = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready === 1) begin dd = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1);
    chk(34'(s_axi_bresp), 34'h0);
  endtask : wr
  task rd(input logic [5:0] a, input logic [33:0] e);
    q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge ref_clk); while (s_axi_arready !== 1);
    s_axi_arvalid <= 0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1);
  endtask : rd
  task pk(input int w);
    fire <= 1;
    @(posedge ref_clk);
    fire <= 0;
    repeat (w) @(posedge ref_clk);
  endtask : pk
  task win;
    n = 0;
    repeat (40) @(posedge ref_clk) n += (backplane_trigger_line_n_oe === 1 && backplane_trigger_line_n_out === 0);
  endtask : win
  task finish_test;
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  always @(posedge ref_clk) begin
    if (s_axi_rvalid === 1) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    cyc++;
    if (cyc == 5000) begin miscompares++; finish_test(); end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 0;
    @(posedge ref_clk);
    im = 16'(xs());
    tl = 16'(xs());
    rd(6'h00, 34'h0);
    rd(6'h3c, 34'h200000000);
    rd(6'h10, 34'h14);
    wr(6'h08, {16'h0, im});
    wr(6'h0c, {16'h0, tl});
    wr(6'h10, 32'h5);
    wr(6'h00, 32'h0);
    chk(34'(setpoint), 34'(im));
    pk(20);
    chk(34'(setpoint), 34'(im));
    wr(6'h04, 32'h1);
    rd(6'h14, 34'h20);
    pk(6);
    chk(34'(setpoint), 34'(im));
    repeat (14) @(posedge ref_clk);
    chk(34'(setpoint), 34'(tl));
    chk(34'(irq), 34'h0);
    rd(6'h18, 34'h3);
    wr(6'h08, {16'h0, im});
    wr(6'h10, 32'h0);
    wr(6'h1c, 32'h7);
    wr(6'h20, 32'h2);
    wr(6'h00, 32'h6);
    wr(6'h04, 32'h1);
    constant_current_state <= 1;
    win();
    chk(34'(n), 34'h8);
    chk(34'(setpoint), 34'(tl));
    chk(34'(irq), 34'h1);
    wr(6'h1c, 32'h7);
    repeat (2) @(posedge ref_clk);
    chk(34'(irq), 34'h0);
    wr(6'h00, 32'h8);
    constant_current_state <= 0;
    repeat (10) @(posedge ref_clk);
    constant_current_state <= 1;
    win();
    chk(34'(n), 34'h0);
    chk(34'(fault_indicator_output), 34'h1);
    wr(6'h08, {16'h0, im});
    wr(6'h00, 32'h1);
    wr(6'h04, 32'h1);
    wr(6'h04, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk(34'(setpoint), 34'(tl));
    wr(6'h00, 32'h8);
    ce <= 0;
    constant_current_state <= 0;
    repeat (10) @(posedge ref_clk);
    chk(34'(fault_indicator_output), 34'h0);
    ce <= 1;
    repeat (10) @(posedge ref_clk);
    chk(34'(fault_indicator_output), 34'h1);
    finish_test();
  end
endmodule : event_trigger_sequencer_bench
`default_nettype wire
